// [rtl/scj_top.sv]
// quick stop current limit, jerk limitation and forced outputs of the motion support logic
// Overview of operation
// - quick stop limit: lowest of three currents
// - setting checked only against own range
// - thermal reduction applies on top during stop
// - setting is unsigned 16 bit, 0.01 A steps
// - new stop current takes effect at once
// - jerk code: 0 off, powers of two ms
// - smooth acceleration changes when limitation enabled
// - limitation only in jog and homing
// - jerk writes only while mode finished
// - new jerk value used from next movement
// - force word bits 0..2 drive outputs 0..2
// - force only present, freely available outputs
`timescale 1ns/100ps
module scj_top #(
	parameter int unsigned  VW          = 32,                   // velocity word width
	parameter int unsigned  DEPTH       = 128,                  // longest smoothing window
	parameter int unsigned  STEP_CYC    = scj_pkg::JERK_STEP_CYC, // cycles per millisecond
	parameter logic [15:0]  QSTP_MIN    = 16'h0000,             // lowest legal stop current
	parameter logic [15:0]  QSTP_MAX    = 16'hffff,             // highest legal stop current
	parameter logic [15:0]  QSTP_RST    = scj_pkg::QSTP_RST,    // stop current after reset
	parameter logic [2:0]   DQ_PRESENT  = 3'h7                  // pins built as outputs
) (
	// clock, reset, enable
	input  wire logic                i_sys_clk,
	input  wire logic                i_rstn,
	input  wire logic                i_clk_en,
	// parameter access from the fieldbus
	input  wire logic                i_par_wr,
	input  wire logic                i_par_rd,
	input  wire logic [15:0]         i_par_addr,
	input  wire logic [15:0]         i_par_wdata,
	output logic      [15:0]         o_par_rdata,
	output logic                     o_par_ack,
	output logic                     o_par_err,
	// current limits, all in 0.01 A rms
	input  wire logic                i_quick_stop,
	input  wire logic [15:0]         i_motor_max_current,
	input  wire logic [15:0]         i_stage_max_current,
	input  wire logic [15:0]         i_thermal_overload_integral,
	output logic      [15:0]         o_active_current_limit,
	// motion profile
	input  wire logic                i_mode_finished,
	input  wire logic                i_mode_jog,
	input  wire logic                i_mode_homing,
	input  wire logic                i_move_start,
	input  wire logic signed [VW-1:0] i_vel_raw,
	output logic signed [VW-1:0]     o_vel_smooth,
	// digital outputs
	input  wire logic [2:0]          i_dq_free,
	input  wire logic [2:0]          i_dq_func,
	output logic                     o_digital_out_zero,
	output logic                     o_digital_out_one,
	output logic                     o_digital_out_two
);
	localparam int unsigned TW = $clog2(STEP_CYC + 1);

	// ********************************************************************
	// reset synchroniser
	// ********************************************************************
	logic rst_meta_q; // first stage, read only by the second
	logic rst_n_q;    // released reset for the whole block

	// asynchronous assert, release after two edges
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	logic [15:0]          qstp_cur_q;   // quick stop current setting
	logic [15:0]          jerk_set_q;   // jerk setting as written
	logic [2:0]           jerk_sh_q;    // exponent in use for this movement
	logic                 jerk_on_q;    // limitation on for this movement
	logic [2:0]           force_q;      // forced output levels
	logic [2:0]           dq_q;         // output pins
	logic [15:0]          ilim_q;       // active current limit
	logic [15:0]          rdata_q;      // read answer
	logic                 ack_q;        // access answered
	logic                 err_q;        // access refused
	logic [TW-1:0]        step_cnt_q;   // millisecond divider
	logic                 tick_q;       // one millisecond has elapsed

	// ********************************************************************
	// address decode and write checks
	// ********************************************************************
	wire hit_jerk  = (i_par_addr == scj_pkg::ADDR_JERK_SMOOTHING_TIME);
	wire hit_force = (i_par_addr == scj_pkg::ADDR_OUTPUT_FORCE_WORD);
	wire hit_qstp  = (i_par_addr == scj_pkg::ADDR_QUICK_STOP_CURRENT_SETTING);
	wire hit_any   = hit_jerk | hit_force | hit_qstp;
	wire par_req   = i_par_wr | i_par_rd;

	// jerk code decode: zero or a single power of two up to 128
	wire       jerk_zero  = (i_par_wdata == 16'h0000);
	wire       jerk_pow2  = ((i_par_wdata & (i_par_wdata - 16'h0001)) == 16'h0000);
	wire       jerk_range = (i_par_wdata <= (16'h0001 << scj_pkg::JERK_MAX_SH));
	wire       jerk_legal = jerk_zero | (jerk_pow2 & jerk_range);
	wire [2:0] sh_stored;                                         // log2 of stored code

	// stop current: own range only, no clamp to motor or stage limits
	wire qstp_legal = (i_par_wdata >= QSTP_MIN) && (i_par_wdata <= QSTP_MAX);

	// write acceptance per register
	wire wr_jerk  = i_par_wr & hit_jerk & jerk_legal & i_mode_finished;
	wire wr_force = i_par_wr & hit_force;
	wire wr_qstp  = i_par_wr & hit_qstp & qstp_legal;
	wire wr_bad   = i_par_wr & ((hit_jerk & ~(jerk_legal & i_mode_finished))
		| (hit_qstp & ~qstp_legal));
	wire req_bad  = (par_req & ~hit_any) | wr_bad;

	// exponent of the stored code; priority picks the single set bit
	function automatic logic [2:0] scj_log2(input logic [15:0] code);
		logic [2:0] r;
		r = 3'h0;
		for (int k = 0; k <= int'(scj_pkg::JERK_MAX_SH); k++) begin
			if (code[k]) begin
				r = 3'(k);
			end
		end
		return r;
	endfunction

	assign sh_stored = scj_log2(jerk_set_q);

	// read mux; unused force bits read zero
	wire [15:0] rd_mux = hit_jerk  ? jerk_set_q :
		hit_force ? {13'h0000, force_q} :
		hit_qstp  ? qstp_cur_q : 16'h0000;

	// ********************************************************************
	// parameter registers
	// ********************************************************************

	// stored values, reset to defined defaults
	always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			qstp_cur_q <= QSTP_RST;
			jerk_set_q <= scj_pkg::JERK_RST;
			force_q    <= scj_pkg::FORCE_RST;
		end else if (i_clk_en) begin
			if (wr_qstp) begin
				qstp_cur_q <= i_par_wdata;
			end
			if (wr_jerk) begin
				jerk_set_q <= i_par_wdata;
			end
			if (wr_force) begin
				// only the low three bits are kept
				force_q <= i_par_wdata[scj_pkg::DQ_LSB +: scj_pkg::DQ_N];
			end
		end
	end

	// access answer one cycle after the request
	always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= 16'h0000;
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
		end else if (i_clk_en) begin
			ack_q   <= par_req;
			err_q   <= req_bad;
			rdata_q <= (i_par_rd & hit_any) ? rd_mux : 16'h0000;
		end
	end

	// ********************************************************************
	// current limit
	// ********************************************************************
	// the stop setting is read live, so a write acts on the very next cycle
	wire [15:0] ms_min   = (i_motor_max_current < i_stage_max_current) ?
		i_motor_max_current : i_stage_max_current;
	wire [15:0] qs_min   = (qstp_cur_q < ms_min) ? qstp_cur_q : ms_min;
	wire [15:0] th_cap   = i_quick_stop ? qs_min : ms_min;
	wire [15:0] ilim_d   = (i_thermal_overload_integral < th_cap) ?
		i_thermal_overload_integral : th_cap;

	// registered limit; outside a stop the stop setting plays no part
	always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ilim_q <= 16'h0000;
		end else if (i_clk_en) begin
			ilim_q <= ilim_d;
		end
	end

	// ********************************************************************
	// jerk limitation
	// ********************************************************************
	// millisecond divider for the smoothing steps
	wire step_end = (step_cnt_q == TW'(STEP_CYC - 1));

	always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			step_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (i_clk_en) begin
			step_cnt_q <= step_end ? '0 : step_cnt_q + TW'(1);
			tick_q     <= step_end;
		end
	end

	// the setting is copied only as a movement starts, so a running move keeps its shape
	always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			jerk_sh_q <= 3'h0;
			jerk_on_q <= 1'b0;
		end else if (i_clk_en && i_move_start) begin
			jerk_sh_q <= sh_stored;
			jerk_on_q <= (jerk_set_q != 16'h0000);
		end
	end

	// the filter reloads on the move start edge itself, so it must see the new
	// exponent in that cycle; the latched copy only takes over afterwards
	wire [2:0] sh_use = i_move_start ? sh_stored : jerk_sh_q;

	scj_jerk_if #(.VW(VW)) jerk_bus ();

	assign jerk_bus.tick    = tick_q;
	assign jerk_bus.restart = i_move_start;
	assign jerk_bus.en      = jerk_on_q & (i_mode_jog | i_mode_homing);
	assign jerk_bus.shift   = sh_use;
	assign jerk_bus.vin     = i_vel_raw;

	// smoother; its output is already a flip-flop
	scj_jerk_filter #(
		.VW    (VW),
		.DEPTH (DEPTH)
	) u_filter (
		.i_clk    (i_sys_clk),
		.i_rst_n  (rst_n_q),
		.i_clk_en (i_clk_en),
		.jif      (jerk_bus)
	);

	// ********************************************************************
	// digital outputs
	// ********************************************************************
	// a pin follows the force word only when built as output and freely available;
	// otherwise its assigned function keeps control
	for (genvar g = 0; g < int'(scj_pkg::DQ_N); g++) begin : g_dq
		wire forced = DQ_PRESENT[g] & i_dq_free[g];
		always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
			if (!rst_n_q) begin
				dq_q[g] <= 1'b0;
			end else if (i_clk_en) begin
				dq_q[g] <= forced ? force_q[g] : i_dq_func[g];
			end
		end
	end

	// ********************************************************************
	// output ports
	// ********************************************************************
	// every port copies a flip-flop, so nothing settles after the edge
	assign o_par_rdata            = rdata_q;
	assign o_par_ack              = ack_q;
	assign o_par_err              = err_q;
	assign o_active_current_limit = ilim_q;
	assign o_vel_smooth           = jerk_bus.vout;
	assign o_digital_out_zero     = dq_q[0];
	assign o_digital_out_one      = dq_q[1];
	assign o_digital_out_two      = dq_q[2];

endmodule : scj_top

// [rtl/scj_pkg.sv]
// package with register map, reset values and timing constants of the stop/jerk/output block
package scj_pkg;

	// ********************************************************************
	// parameter addresses
	// ********************************************************************
	localparam logic [15:0] ADDR_JERK_SMOOTHING_TIME        = 16'h061a; // jerk setting
	localparam logic [15:0] ADDR_OUTPUT_FORCE_WORD          = 16'h0822; // output force word
	localparam logic [15:0] ADDR_QUICK_STOP_CURRENT_SETTING = 16'h111a; // quick stop current

	// ********************************************************************
	// widths and field positions
	// ********************************************************************
	localparam int unsigned PAR_W       = 16; // every parameter is a 16-bit word
	localparam int unsigned DQ_N        = 3;  // outputs reachable through the force word
	localparam int unsigned DQ_LSB      = 0;  // bit of the first output in the force word
	localparam int unsigned JERK_SH_W   = 3;  // width of the smoothing exponent
	localparam int unsigned JERK_MAX_SH = 7;  // 128 ms is two to the seventh

	// ********************************************************************
	// reset values
	// ********************************************************************
	localparam logic [15:0] JERK_RST  = 16'h0000; // jerk limitation off
	localparam logic [2:0]  FORCE_RST = 3'h0;     // forced outputs low
	localparam logic [15:0] QSTP_RST  = 16'hffff; // plain default, top parameter overrides

	// ********************************************************************
	// timing: smoothing steps are whole milliseconds
	// ********************************************************************
	localparam int unsigned CLK_PERIOD_NS = 10;      // 100 MHz system clock
	localparam int unsigned JERK_STEP_MS  = 1;       // one smoothing step
	localparam int unsigned NS_PER_MS     = 1000000; // unit conversion
	localparam int unsigned JERK_STEP_CYC = JERK_STEP_MS * NS_PER_MS / CLK_PERIOD_NS;

endpackage : scj_pkg

// [rtl/scj_jerk_if.sv]
// interface carrying the smoothing controls and velocity between top and filter
`timescale 1ns/100ps
interface scj_jerk_if #(
	parameter int unsigned VW = 32 // velocity word width
);
	logic                 tick;    // one smoothing step has elapsed
	logic                 restart; // a new movement starts, reload the window
	logic                 en;      // smoothing active for this mode and setting
	logic [2:0]           shift;   // window length is two to this power
	logic signed [VW-1:0] vin;     // raw velocity from the profile generator
	logic signed [VW-1:0] vout;    // smoothed velocity

	modport ctrl (output tick, output restart, output en, output shift, output vin, input vout);
	modport filt (input tick, input restart, input en, input shift, input vin, output vout);
endinterface : scj_jerk_if

// [rtl/scj_jerk_filter.sv]
// moving-average velocity smoother that turns acceleration steps into ramps
`timescale 1ns/100ps
module scj_jerk_filter #(
	parameter int unsigned VW    = 32,  // velocity word width
	parameter int unsigned DEPTH = 128  // longest window in steps
) (
	// clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_clk_en,
	// controls and data
	scj_jerk_if.filt   jif
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned SW = VW + AW + 1;

	// ********************************************************************
	// storage and running sum
	// ********************************************************************
	logic signed [VW-1:0] mem [DEPTH];   // history of raw velocity
	logic [AW-1:0]        wp_q;          // next write slot
	logic [AW:0]          fill_q;        // steps left that still use the preload
	logic signed [VW-1:0] v0_q;          // velocity at movement start
	logic signed [SW-1:0] sum_q;         // sum over the window
	logic signed [VW-1:0] vout_q;        // registered output

	// ********************************************************************
	// window arithmetic
	// ********************************************************************
	wire [AW:0]          win_len  = (AW+1)'(1) << jif.shift;          // samples in window
	wire [AW-1:0]        rd_ptr   = wp_q - win_len[AW-1:0];            // sample leaving
	wire signed [VW-1:0] v_old    = (fill_q != '0) ? v0_q : mem[rd_ptr];
	wire signed [SW-1:0] sum_next = sum_q + SW'(jif.vin) - SW'(v_old);
	wire signed [SW-1:0] sum_pre  = SW'(jif.vin) <<< jif.shift;       // window full of v0
	wire signed [SW-1:0] avg      = sum_next >>> jif.shift;

	assign jif.vout = vout_q;

	// history write: plain memory, no reset needed since the preload covers it
	always_ff @(posedge i_clk) begin
		if (i_clk_en && jif.tick) begin
			mem[wp_q] <= jif.vin;
		end
	end

	// window state; a restart beats a coinciding step so the new length is clean
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_q   <= '0;
			fill_q <= '0;
			v0_q   <= '0;
			sum_q  <= '0;
			vout_q <= '0;
		end else if (i_clk_en) begin
			if (jif.restart) begin
				fill_q <= win_len;
				v0_q   <= jif.vin;
				sum_q  <= sum_pre;
				vout_q <= jif.vin;
			end else if (jif.tick) begin
				wp_q   <= wp_q + AW'(1);
				fill_q <= (fill_q != '0) ? fill_q - (AW+1)'(1) : fill_q;
				sum_q  <= sum_next;
				// disabled smoothing passes the raw velocity straight on
				vout_q <= jif.en ? VW'(avg) : jif.vin;
			end
		end
	end
endmodule : scj_jerk_filter

// [tb/scj_top_props.sv]
// assertion checker watching the ports of the stop/jerk/output block
`timescale 1ns/100ps
module scj_top_props #(
	parameter logic [15:0] QSTP_MIN = 16'h0000, // lowest legal stop current
	parameter logic [15:0] QSTP_MAX = 16'hffff  // highest legal stop current
) (
	// clock, reset and enable
	input wire logic        i_sys_clk, i_rstn, i_clk_en,
	// parameter access
	input wire logic        i_par_wr, i_par_rd, o_par_ack, o_par_err,
	input wire logic [15:0] i_par_addr, i_par_wdata,
	// current limits
	input wire logic        i_quick_stop,
	input wire logic [15:0] i_motor_max_current, i_stage_max_current,
	input wire logic [15:0] i_thermal_overload_integral, o_active_current_limit,
	// mode and outputs
	input wire logic        i_mode_finished, o_digital_out_zero, o_digital_out_one,
	input wire logic        o_digital_out_two,
	input wire logic [2:0]  i_dq_free, i_dq_func
);
	// ************************************************************
	// helpers and properties
	// ************************************************************
	logic [1:0] live_q; // the internal reset copy lags release by two edges
	always_ff @(posedge i_sys_clk or negedge i_rstn)
		if (!i_rstn) live_q <= 2'h0;
		else if (live_q != 2'h3) live_q <= live_q + 2'h1;
	wire        live = (live_q == 2'h3) && i_clk_en; // outputs trustworthy
	wire        req  = i_par_wr || i_par_rd;
	wire        jw   = i_par_wr && (i_par_addr == scj_pkg::ADDR_JERK_SMOOTHING_TIME);
	wire        qw   = i_par_wr && (i_par_addr == scj_pkg::ADDR_QUICK_STOP_CURRENT_SETTING);
	wire        fw   = i_par_wr && (i_par_addr == scj_pkg::ADDR_OUTPUT_FORCE_WORD);
	wire        map  = (i_par_addr == scj_pkg::ADDR_JERK_SMOOTHING_TIME) ||
	                   (i_par_addr == scj_pkg::ADDR_OUTPUT_FORCE_WORD) ||
	                   (i_par_addr == scj_pkg::ADDR_QUICK_STOP_CURRENT_SETTING);
	wire        jok  = (i_par_wdata == 16'h0000) ||
	                   (i_par_wdata <= 16'h0080 && $onehot(i_par_wdata));
	wire        qbad = (i_par_wdata < QSTP_MIN) || (i_par_wdata > QSTP_MAX);
	wire [15:0] mt   = (i_motor_max_current < i_stage_max_current) ? i_motor_max_current
	                                                                : i_stage_max_current;
	wire [15:0] m3   = (mt < i_thermal_overload_integral) ? mt : i_thermal_overload_integral;
	wire [2:0]  fd   = i_par_wdata[2:0];
	wire [2:0]  pins = {o_digital_out_two, o_digital_out_one, o_digital_out_zero};
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	// a stop current write below the other limits, then a quiet cycle
	sequence qs_wr_s; live && qw && i_quick_stop && (i_par_wdata < m3); endsequence
	sequence qs_hold_s; live && !i_par_wr && i_quick_stop && $stable(m3); endsequence
	// a force word write with all outputs free, then a quiet cycle
	sequence fw_s; live && fw && (&i_dq_free); endsequence
	sequence fhold_s; live && !i_par_wr && (&i_dq_free); endsequence
	ack_per_req_a: assert property (live |=> o_par_ack == $past(req))
		else $error("ack does not match request");
	unmapped_err_a: assert property (live && req && !map |=> o_par_err)
		else $error("unmapped access not refused");
	jerk_busy_a: assert property (live && jw && !i_mode_finished |=> o_par_err)
		else $error("jerk write accepted while mode active");
	jerk_code_a: assert property (live && jw && i_mode_finished |=> o_par_err != $past(jok))
		else $error("jerk code legality wrong");
	qstp_range_a: assert property (live && qw |=> o_par_err == $past(qbad))
		else $error("stop current range check wrong");
	limit_free_a: assert property (live && !i_quick_stop |=>
		o_active_current_limit == $past(m3))
		else $error("limit outside stop wrong");
	limit_stop_a: assert property (live && i_quick_stop |=> o_active_current_limit <= $past(m3))
		else $error("stop limit above other limits");
	qstp_now_a: assert property (qs_wr_s ##1 qs_hold_s |=>
		o_active_current_limit == $past(i_par_wdata, 2))
		else $error("stop current not applied at once");
	force_pin_a: assert property (fw_s ##1 fhold_s |=> pins == $past(fd, 2))
		else $error("forced pins differ from written bits");
	own_func_a: assert property (live |=>
		((pins ^ $past(i_dq_func)) & ~$past(i_dq_free)) == 3'h0)
		else $error("unfree output left its function");
endmodule // scj_top_props

// [tb/scj_fb_master.sv]
// fieldbus master model that writes and reads drive parameters
`timescale 1ns/100ps
module scj_fb_master (
	// clock and mode status
	input  wire logic   i_clk,
	input  wire logic   i_mode_finished,
	// parameter requests
	output logic        o_wr,
	output logic        o_rd,
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
	end
	// one access: a one-edge pulse, then the answer edge; released lines show the inverse
	task automatic acc(input logic w, input logic [15:0] a, d, input logic rude);
		int k;
		// a polite master waits for the mode to finish before a jerk write
		for (k = 0; k < 64 && w && !rude && a == scj_pkg::ADDR_JERK_SMOOTHING_TIME
			&& !i_mode_finished; k++) begin
			@(posedge i_clk);
		end
		@(posedge i_clk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		@(posedge i_clk);
	endtask
endmodule // scj_fb_master

// [tb/testbench.sv]
// self-checking bench for the stop/jerk/output block
`timescale 1ns/100ps
module testbench;
	// ************************************************************
	// signals, expectation queues and helpers
	// ************************************************************
	localparam logic [15:0] AJ = scj_pkg::ADDR_JERK_SMOOTHING_TIME;
	localparam logic [15:0] AF = scj_pkg::ADDR_OUTPUT_FORCE_WORD;
	localparam logic [15:0] AQ = scj_pkg::ADDR_QUICK_STOP_CURRENT_SETTING;
	logic               i_sys_clk, i_rstn, i_clk_en, i_quick_stop, i_mode_finished;
	logic               i_mode_jog, i_mode_homing, i_move_start;
	logic        [15:0] i_motor_max_current, i_stage_max_current, i_thermal_overload_integral;
	logic        [2:0]  i_dq_free, i_dq_func;
	logic signed [31:0] i_vel_raw;
	wire                i_par_wr, i_par_rd, o_par_ack, o_par_err;
	wire                o_digital_out_zero, o_digital_out_one, o_digital_out_two;
	wire         [15:0] i_par_addr, i_par_wdata, o_par_rdata, o_active_current_limit;
	wire signed  [31:0] o_vel_smooth;
	logic        [16:0] bq[$];        // expected {err, rdata} per access
	logic        [31:0] vq[$];        // expected smoothed velocity changes
	logic        [31:0] vl   = 0;     // last velocity seen
	logic        [31:0] vexp = 0;     // last velocity expected
	logic        [15:0] c, v;
	logic        [16:0] be;           // oldest noted bus answer
	int                 n_errors = 0, n_checks = 0, seed;
	// short step count keeps the smoothing run brief
	scj_top #(.STEP_CYC(4)) i_dut (.*);
	scj_fb_master i_fbm (.i_clk(i_sys_clk), .i_mode_finished(i_mode_finished), .o_wr(i_par_wr),
		.o_rd(i_par_rd), .o_addr(i_par_addr), .o_wdata(i_par_wdata));
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	task automatic cmp(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one compare per kind of result; cmp itself serves the velocity
	task automatic cmp_bus(input logic [16:0] g, e);
		cmp(32'(g), 32'(e));
	endtask
	task automatic cmp_lim(input logic [15:0] g, e);
		cmp(32'(g), 32'(e));
	endtask
	task automatic cmp_pin(input logic [2:0] g, e);
		cmp(32'(g), 32'(e));
	endtask
	task automatic end_of_test();
		n_errors += bq.size() + vq.size();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// note the answer, then let the master make the access
	task automatic acc(input logic w, input logic [15:0] a, d, input logic er,
		input logic [15:0] rd, input logic rude = 1'b0);
		bq.push_back({er, rd});
		i_fbm.acc(w, a, d, rude);
	endtask
	function automatic logic [15:0] mn(input logic [15:0] s, input logic q);
		logic [15:0] m;
		m = (i_motor_max_current < i_stage_max_current) ? i_motor_max_current : i_stage_max_current;
		if (i_thermal_overload_integral < m) m = i_thermal_overload_integral;
		if (q && s < m) m = s;
		return m;
	endfunction
	// restart a movement, rewrite the jerk code mid-move, then step the velocity
	task automatic ramp(input logic j, h, input logic [15:0] nc, input int n);
		@(posedge i_sys_clk);
		i_mode_jog <= j;
		i_mode_homing <= h;
		i_vel_raw <= 0;
		i_move_start <= 1'b1;
		if (vexp != 0) vq.push_back(0);
		@(posedge i_sys_clk);
		i_move_start <= 1'b0;
		acc(1, AJ, nc, 0, 0);
		repeat (8) @(posedge i_sys_clk);
		for (int k = 1; k <= n; k++) vq.push_back(800 * k / n);
		i_vel_raw <= 800;
		repeat (4 * n + 12) @(posedge i_sys_clk);
		vexp = 800;
	endtask
	// ************************************************************
	// monitors, watchdog and main sequence
	// ************************************************************
	always @(posedge i_sys_clk) begin
		if (o_par_ack === 1'b1) begin
			be = (bq.size() > 0) ? bq.pop_front() : 17'h1ffff;
			cmp_bus({o_par_err, o_par_rdata}, be);
		end
		if (o_vel_smooth !== vl) begin
			vl = o_vel_smooth;
			cmp(vl, (vq.size() > 0) ? vq.pop_front() : 32'hdeadbeef);
		end
	end
	initial begin
		#400000;
		n_errors++;
		end_of_test();
	end
	initial begin
		seed = 32'h9e11f3a9;
		{i_rstn, i_quick_stop, i_mode_jog, i_mode_homing, i_move_start} = 5'h00;
		{i_clk_en, i_mode_finished} = 2'h3;
		{i_dq_free, i_dq_func, i_vel_raw} = 0;
		{i_motor_max_current, i_stage_max_current, i_thermal_overload_integral} = {3{16'h0100}};
		repeat (16) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		// reset values, then unmapped places
		acc(0, AJ, 0, 0, 16'h0000);
		acc(0, AF, 0, 0, 16'h0000);
		acc(0, AQ, 0, 0, scj_pkg::QSTP_RST);
		acc(0, 16'h0123, 0, 1, 0);
		acc(1, 16'h0124, 16'h5a5a, 1, 0);
		for (int i = 0; i < 9; i++) begin
			c = (i == 0) ? 16'h0000 : 16'h0001 << (i - 1);
			acc(1, AJ, c, 0, 0);
			acc(0, AJ, 0, 0, c);
		end
		acc(1, AJ, 16'h0003, 1, 0);
		acc(1, AJ, 16'h0081, 1, 0);
		i_mode_finished <= 1'b0;
		acc(1, AJ, 16'h0004, 1, 0, 1);
		i_mode_finished <= 1'b1;
		acc(0, AJ, 0, 0, 16'h0080);
		// stop current written with random limits, in and out of a stop
		for (int i = 0; i < 8; i++) begin
			i_motor_max_current <= 16'($random(seed));
			i_stage_max_current <= 16'($random(seed));
			i_thermal_overload_integral <= 16'($random(seed));
			i_quick_stop <= i[0];
			// one tiny setting during a stop surely undercuts the random limits
			v = (i == 1) ? 16'h0001 : 16'($random(seed));
			acc(1, AQ, v, 0, 0);
			@(negedge i_sys_clk);
			cmp_lim(o_active_current_limit, mn(v, i[0]));
			acc(0, AQ, 0, 0, v);
		end
		// force word with a random mix of free outputs
		for (int i = 0; i < 8; i++) begin
			// all outputs free once, so every forced bit reaches its pin
			i_dq_free <= (i == 0) ? 3'h7 : 3'($random(seed));
			i_dq_func <= 3'($random(seed));
			v = 16'($random(seed));
			acc(1, AF, v, 0, 0);
			@(negedge i_sys_clk);
			cmp_pin({o_digital_out_two, o_digital_out_one, o_digital_out_zero},
				(i_dq_free & v[2:0]) | (~i_dq_free & i_dq_func));
			acc(0, AF, 0, 0, {13'h0000, v[2:0]});
		end
		// enable low: pins hold while their inputs move, then follow again
		c[2:0] = (i_dq_free & v[2:0]) | (~i_dq_free & i_dq_func);
		i_clk_en <= 1'b0;
		i_dq_free <= 3'h0;
		i_dq_func <= ~c[2:0];
		repeat (3) @(posedge i_sys_clk);
		cmp_pin({o_digital_out_two, o_digital_out_one, o_digital_out_zero}, c[2:0]);
		i_clk_en <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		cmp_pin({o_digital_out_two, o_digital_out_one, o_digital_out_zero}, ~c[2:0]);
		// smoothing by mode and code
		acc(1, AJ, 16'h0004, 0, 0);
		ramp(1, 0, 16'h0002, 4);
		ramp(0, 0, 16'h0002, 1);
		ramp(0, 1, 16'h0000, 2);
		ramp(1, 0, 16'h0000, 1);
		end_of_test();
	end
endmodule // testbench
bind scj_top scj_top_props #(.QSTP_MIN(QSTP_MIN), .QSTP_MAX(QSTP_MAX)) i_props (.*);
